// ===== hw/sacc_pkg.sv
// Package with register map, field layout, reset values and carriers of the converter config.
package sacc_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_PROX_GAIN_CFG  = 8'h0b;
   localparam logic [7:0] IDX_PROX_MISC_CFG  = 8'h0c;
   localparam logic [7:0] IDX_AMB_IR_IN_CFG  = 8'h0e;
   localparam logic [7:0] IDX_AUX_IN_CFG     = 8'h0f;
   localparam int         ADDR_SHIFT         = 2;

   // ----------------------------------------------------------------
   // Field positions and writable masks.
   // ----------------------------------------------------------------
   localparam int         GAIN_MSB           = 2;
   localparam int         RANGE_BIT          = 5;
   localparam int         MODE_BIT           = 2;
   localparam logic [7:0] GAIN_WMASK         = 8'h07;
   localparam logic [7:0] MISC_WMASK         = 8'h24;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PROX_GAIN      = 8'h00;
   localparam logic [7:0] RST_PROX_MISC      = 8'h04;
   localparam logic [7:0] RST_AMB_IR_IN      = 8'h00;
   localparam logic [7:0] RST_AUX_IN         = 8'h65;

   // ----------------------------------------------------------------
   // Input selector codes.
   // ----------------------------------------------------------------
   localparam logic [7:0] SEL_IR_SMALL       = 8'h00;
   localparam logic [7:0] SEL_IR_LARGE       = 8'h03;
   localparam logic [7:0] SEL_AUX_TEMP       = 8'h65;
   localparam logic [7:0] SEL_AUX_VDD        = 8'h75;

   // ----------------------------------------------------------------
   // Timing, in converter clock ticks before scaling by the gain.
   // ----------------------------------------------------------------
   localparam int         LED_PULSE_TICKS    = 16;
   localparam int         INTEG_TICKS        = 32;
   localparam int         MAX_GAIN           = 7;

   // ----------------------------------------------------------------
   // Types.
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ      = 2'b10;
   localparam logic [1:0] HTRANS_SEQ         = 2'b11;

   typedef struct packed {
      logic [2:0] prox_gain_exponent;
      logic       prox_high_range;
      logic       prox_meas_mode_sel;
      logic [7:0] ambient_ir_input_select;
      logic [7:0] auxiliary_input_select;
   } sacc_cfg_s;

   typedef struct packed {
      logic       amb_ir_large;
      logic       aux_temp;
      logic       aux_vdd;
   } sacc_sel_s;

   typedef enum logic [1:0] {
      SACC_IDLE  = 2'b00,
      SACC_PULSE = 2'b01,
      SACC_INTEG = 2'b11,
      SACC_DONE  = 2'b10
   } sacc_state_e;

endpackage

// ===== hw/sacc_top.sv
// Converter channel configuration registers with an AHB-Lite slave and a measurement timer.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Gain scales LED pulse and integration time
// - Converter clock divided by two to gain
// - Any written gain applied without clamping
// - Range bit five selects high range
// - Mode bit two: raw or normal proximity
// - Misc setting resets to normal mode, range
// - Ambient IR selector routes small or large
// - Aux selector picks temperature or supply
// - Aux selector resets to temperature code
// - Gain and IR selector reset to zero
// - Raw mode disables the LED drive
module sacc_top #(
   parameter int LED_TICKS   = sacc_pkg::LED_PULSE_TICKS,
   parameter int INTEG_TICKS = sacc_pkg::INTEG_TICKS
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output      logic                hreadyout,
   output      logic                hresp,
   output      logic [31:0]         hrdata,
   input  wire logic                meas_start,
   output      sacc_pkg::sacc_cfg_s meas_cfg,
   output      sacc_pkg::sacc_sel_s meas_sel,
   output      logic                adc_clk_tick,
   output      logic                led_drive_on,
   output      logic                integrating,
   output      logic                meas_busy,
   output      logic                meas_done
);

   // ----------------------------------------------------------------
   // Elaboration checks.
   // ----------------------------------------------------------------
   localparam int CNT_W = sacc_pkg::MAX_GAIN + 1;
   localparam int TICK_W = 16;

   if (LED_TICKS < 1 || INTEG_TICKS <= LED_TICKS ||
       INTEG_TICKS >= (1 << TICK_W)) begin : g_bad_ticks
      // The tick counter must hold the integration count, and the pulse must end before it.
      $error("sacc_top: tick counts out of range");
   end

   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------
   function automatic logic [3:0] decode(input logic [31:0] addr);
      logic [29:0] idx;
      idx = addr[31:sacc_pkg::ADDR_SHIFT];
      decode = 4'h0;
      if (addr[1:0] == 2'h0) begin
         decode[0] = (idx == 30'(sacc_pkg::IDX_PROX_GAIN_CFG));
         decode[1] = (idx == 30'(sacc_pkg::IDX_PROX_MISC_CFG));
         decode[2] = (idx == 30'(sacc_pkg::IDX_AMB_IR_IN_CFG));
         decode[3] = (idx == 30'(sacc_pkg::IDX_AUX_IN_CFG));
      end
   endfunction

   logic        [3:0] wr_sel;
   logic              wr_pend;
   logic        [7:0] prox_gain_cfg;
   logic        [7:0] prox_misc_cfg;
   logic        [7:0] ambient_ir_input_cfg;
   logic        [7:0] auxiliary_input_cfg;
   logic        [7:0] next_prox_gain_cfg;
   logic        [7:0] next_prox_misc_cfg;
   logic        [7:0] next_ambient_ir_input_cfg;
   logic        [7:0] next_auxiliary_input_cfg;
   logic        [3:0] rd_sel;
   logic              addr_phase;
   logic        [7:0] next_rdata;

   assign addr_phase = hsel && hready && (htrans == sacc_pkg::HTRANS_NONSEQ ||
                                          htrans == sacc_pkg::HTRANS_SEQ);

   // ----------------------------------------------------------------
   // Bus slave: zero wait states, always OKAY.
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_sel  <= 4'h0;
      end else if (hready) begin
         wr_pend <= addr_phase && hwrite;
         wr_sel  <= (addr_phase && hwrite) ? decode(haddr) : 4'h0;
      end
   end

   // Writes land at the end of the data phase; reserved bits are masked off here.
   always_comb begin
      next_prox_gain_cfg        = prox_gain_cfg;
      next_prox_misc_cfg        = prox_misc_cfg;
      next_ambient_ir_input_cfg = ambient_ir_input_cfg;
      next_auxiliary_input_cfg  = auxiliary_input_cfg;
      if (wr_pend && hready) begin
         if (wr_sel[0]) begin
            next_prox_gain_cfg = hwdata[7:0] & sacc_pkg::GAIN_WMASK;
         end
         if (wr_sel[1]) begin
            next_prox_misc_cfg = hwdata[7:0] & sacc_pkg::MISC_WMASK;
         end
         if (wr_sel[2]) begin
            next_ambient_ir_input_cfg = hwdata[7:0];
         end
         if (wr_sel[3]) begin
            next_auxiliary_input_cfg = hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prox_gain_cfg        <= sacc_pkg::RST_PROX_GAIN;
         prox_misc_cfg        <= sacc_pkg::RST_PROX_MISC;
         ambient_ir_input_cfg <= sacc_pkg::RST_AMB_IR_IN;
         auxiliary_input_cfg  <= sacc_pkg::RST_AUX_IN;
      end else begin
         prox_gain_cfg        <= next_prox_gain_cfg;
         prox_misc_cfg        <= next_prox_misc_cfg;
         ambient_ir_input_cfg <= next_ambient_ir_input_cfg;
         auxiliary_input_cfg  <= next_auxiliary_input_cfg;
      end
   end

   // Read data is taken from the next values so a read right after a write sees it.
   assign rd_sel = decode(haddr);

   always_comb begin
      next_rdata = 8'h00;
      case (1'b1)
         rd_sel[0]: next_rdata = next_prox_gain_cfg;
         rd_sel[1]: next_rdata = next_prox_misc_cfg;
         rd_sel[2]: next_rdata = next_ambient_ir_input_cfg;
         rd_sel[3]: next_rdata = next_auxiliary_input_cfg;
         default:   next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= {24'h00_0000, next_rdata};
      end else if (hready) begin
         hrdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Measurement config capture.
   // ----------------------------------------------------------------
   sacc_pkg::sacc_state_e state;
   sacc_pkg::sacc_state_e next_state;
   logic                  start_ok;

   assign start_ok = meas_start && (state == sacc_pkg::SACC_IDLE);

   // A change of settings mid-measurement would tear the timing, so the set is frozen per run.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meas_cfg <= '{prox_gain_exponent:      sacc_pkg::RST_PROX_GAIN[sacc_pkg::GAIN_MSB:0],
                       prox_high_range:         sacc_pkg::RST_PROX_MISC[sacc_pkg::RANGE_BIT],
                       prox_meas_mode_sel:      sacc_pkg::RST_PROX_MISC[sacc_pkg::MODE_BIT],
                       ambient_ir_input_select: sacc_pkg::RST_AMB_IR_IN,
                       auxiliary_input_select:  sacc_pkg::RST_AUX_IN};
         meas_sel <= '{amb_ir_large: 1'b0, aux_temp: 1'b1, aux_vdd: 1'b0};
      end else if (start_ok) begin
         meas_cfg.prox_gain_exponent      <= prox_gain_cfg[sacc_pkg::GAIN_MSB:0];
         meas_cfg.prox_high_range         <= prox_misc_cfg[sacc_pkg::RANGE_BIT];
         meas_cfg.prox_meas_mode_sel      <= prox_misc_cfg[sacc_pkg::MODE_BIT];
         meas_cfg.ambient_ir_input_select <= ambient_ir_input_cfg;
         meas_cfg.auxiliary_input_select  <= auxiliary_input_cfg;
         meas_sel.amb_ir_large <= (ambient_ir_input_cfg == sacc_pkg::SEL_IR_LARGE);
         meas_sel.aux_temp     <= (auxiliary_input_cfg == sacc_pkg::SEL_AUX_TEMP);
         meas_sel.aux_vdd      <= (auxiliary_input_cfg == sacc_pkg::SEL_AUX_VDD);
      end
   end

   // ----------------------------------------------------------------
   // Converter clock divider.
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] div_cnt;
   logic [CNT_W-1:0] div_last;
   logic             tick_now;

   // No clamp on the exponent: the largest value simply divides by the widest count.
   assign div_last = CNT_W'((1 << meas_cfg.prox_gain_exponent) - 1);
   assign tick_now = meas_busy && (div_cnt == div_last);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= '0;
      end else if (!meas_busy || tick_now) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         adc_clk_tick <= 1'b0;
      end else begin
         adc_clk_tick <= tick_now;
      end
   end

   // ----------------------------------------------------------------
   // Pulse and integration sequence.
   // ----------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt;

   always_comb begin
      next_state = state;
      case (state)
         sacc_pkg::SACC_IDLE: begin
            if (start_ok) begin
               next_state = sacc_pkg::SACC_PULSE;
            end
         end
         sacc_pkg::SACC_PULSE: begin
            if (tick_now && tick_cnt == TICK_W'(LED_TICKS - 1)) begin
               next_state = sacc_pkg::SACC_INTEG;
            end
         end
         sacc_pkg::SACC_INTEG: begin
            if (tick_now && tick_cnt == TICK_W'(INTEG_TICKS - 1)) begin
               next_state = sacc_pkg::SACC_DONE;
            end
         end
         sacc_pkg::SACC_DONE: begin
            next_state = sacc_pkg::SACC_IDLE;
         end
         default: begin
            next_state = sacc_pkg::SACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= sacc_pkg::SACC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Counting in divided ticks is what stretches both windows by the gain factor.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt <= '0;
      end else if (start_ok) begin
         tick_cnt <= '0;
      end else if (tick_now) begin
         tick_cnt <= tick_cnt + TICK_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_drive_on <= 1'b0;
         integrating  <= 1'b0;
         meas_busy    <= 1'b0;
         meas_done    <= 1'b0;
      end else begin
         led_drive_on <= (next_state == sacc_pkg::SACC_PULSE) &&
                         (start_ok ? prox_misc_cfg[sacc_pkg::MODE_BIT]
                                   : meas_cfg.prox_meas_mode_sel);
         integrating  <= (next_state == sacc_pkg::SACC_PULSE) ||
                         (next_state == sacc_pkg::SACC_INTEG);
         meas_busy    <= (next_state == sacc_pkg::SACC_PULSE) ||
                         (next_state == sacc_pkg::SACC_INTEG);
         meas_done    <= (next_state == sacc_pkg::SACC_DONE);
      end
   end

endmodule // sacc_top

// ===== verification/sacc_top_props.sv
// Concurrent checks on the ports of the converter configuration block.
`timescale 1ns/1ps
module sacc_top_props #(
   parameter int INTEG_TICKS = 32
) (
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [31:0]         hrdata,
   input wire logic                meas_start,
   input wire sacc_pkg::sacc_cfg_s meas_cfg,
   input wire sacc_pkg::sacc_sel_s meas_sel,
   input wire logic                adc_clk_tick,
   input wire logic                led_drive_on,
   input wire logic                integrating,
   input wire logic                meas_busy,
   input wire logic                meas_done
);
   logic [31:0] bcnt;
   logic [31:0] tcnt;
   logic        seen;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Busy length and tick spacing are counted here because they run past any repetition bound.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcnt <= 32'h0;
      end else begin
         bcnt <= meas_busy ? bcnt + 32'h1 : 32'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tcnt <= 32'h0;
         seen <= 1'b0;
      end else begin
         tcnt <= adc_clk_tick ? 32'h1 : tcnt + 32'h1;
         seen <= meas_busy & (seen | adc_clk_tick);
      end
   end

   chk_bus_okay: assert property (hresetn && $past(hresetn) |-> !hresp && hreadyout)
      else $error("bus answer not ready or not okay");
   chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_reset_cfg: assert property (
      $rose(hresetn) |-> meas_cfg == {3'h0, 1'b0, 1'b1, 8'h00, 8'h65})
      else $error("settings after reset wrong");
   chk_start_busy: assert property (
      meas_start && !meas_busy && !meas_done |=> meas_busy && integrating)
      else $error("start not taken");
   chk_cfg_hold: assert property (meas_busy && $past(meas_busy) |-> $stable(meas_cfg))
      else $error("settings changed inside a measurement");
   chk_raw_no_led: assert property (!meas_cfg.prox_meas_mode_sel |-> !led_drive_on)
      else $error("led driven in raw mode");
   chk_led_window: assert property (led_drive_on |-> meas_busy && integrating)
      else $error("led on outside a measurement");
   chk_busy_len: assert property (
      $fell(meas_busy) |-> bcnt == (INTEG_TICKS << meas_cfg.prox_gain_exponent))
      else $error("integration length wrong");
   chk_tick_space: assert property (
      meas_busy && adc_clk_tick && seen |-> tcnt == (32'h1 << meas_cfg.prox_gain_exponent))
      else $error("converter tick spacing wrong");
   chk_done_pulse: assert property (meas_done |=> !meas_done && !meas_busy)
      else $error("done longer than one cycle");
   chk_sel_decode: assert property (
      meas_sel == {meas_cfg.ambient_ir_input_select == 8'h03,
                   meas_cfg.auxiliary_input_select == 8'h65,
                   meas_cfg.auxiliary_input_select == 8'h75})
      else $error("input selector decode wrong");
endmodule // sacc_top_props

bind sacc_top sacc_top_props #(.INTEG_TICKS(INTEG_TICKS)) u_props (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .meas_start(meas_start), .meas_cfg(meas_cfg), .meas_sel(meas_sel),
   .adc_clk_tick(adc_clk_tick), .led_drive_on(led_drive_on), .integrating(integrating),
   .meas_busy(meas_busy), .meas_done(meas_done));

// ===== verification/testbench.sv
// Self-checking bench for the converter configuration block.
`timescale 1ns/1ps
module testbench;
   localparam int LT = 2;
   localparam int IT = 4;
   logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_start;
   logic [31:0]         haddr, hwdata, hrdata, r;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic                adc_clk_tick, led_drive_on, integrating, meas_busy, meas_done;
   sacc_pkg::sacc_cfg_s meas_cfg;
   sacc_pkg::sacc_sel_s meas_sel;
   int                  bad_count = 0, checks_done = 0, seed, bcnt = 0, lcnt = 0;
   logic [7:0]          rd_q[$];
   logic [55:0]         ms_q[$];
   logic                rd_ph = 1'b0;
   logic [7:0]          idxs[4] = '{8'h0b, 8'h0c, 8'h0e, 8'h0f};
   logic [7:0]          msks[4] = '{8'h07, 8'h24, 8'hff, 8'hff};

   sacc_top #(.LED_TICKS(LT), .INTEG_TICKS(IT)) u_sacc_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas_start(meas_start),
      .meas_cfg(meas_cfg), .meas_sel(meas_sel), .adc_clk_tick(adc_clk_tick),
      .led_drive_on(led_drive_on), .integrating(integrating), .meas_busy(meas_busy),
      .meas_done(meas_done));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Bus master: address phase, then data phase, each held until ready.
   // ----------------------------------------------------------------
   task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= sacc_pkg::HTRANS_NONSEQ;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         bad_count++;
         finish_test();
      end
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      rd_q.push_back(exp);
      bus(idx, 1'b0, $random(seed));
   endtask

   task automatic meas(input logic [2:0] g, input logic [7:0] misc, ir, aux);
      int n;
      n = 0;
      bus(sacc_pkg::IDX_PROX_GAIN_CFG, 1'b1, {r[31:3], g});
      bus(sacc_pkg::IDX_PROX_MISC_CFG, 1'b1, {r[31:8], misc});
      bus(sacc_pkg::IDX_AMB_IR_IN_CFG, 1'b1, {24'h0, ir});
      bus(sacc_pkg::IDX_AUX_IN_CFG, 1'b1, {24'h0, aux});
      ms_q.push_back({g, misc[5], misc[2], ir, aux, ir == 8'h03, aux == 8'h65, aux == 8'h75,
                      16'(IT << g), misc[2] ? 16'(LT << g) : 16'h0});
      meas_start <= 1'b1;
      @(posedge hclk);
      meas_start <= 1'b0;
      bus(sacc_pkg::IDX_PROX_GAIN_CFG, 1'b1, {29'h0, ~g & 3'h5});
      while (ms_q.size() != 0 && n < 2000) begin @(posedge hclk); n++; end
      if (n >= 2000) begin
         bad_count++;
         finish_test();
      end
   endtask

   // Watcher: takes the oldest note whenever a read or a measurement completes.
   always @(posedge hclk) begin
      if (rd_ph === 1'b1)
         check("read data", {24'h0, rd_q.pop_front()}, hrdata);
      rd_ph <= hsel & htrans[1] & ~hwrite & hreadyout;
      if (meas_done === 1'b1) begin
         check("measurement", ms_q.pop_front(),
               {meas_cfg, meas_sel, bcnt[15:0], lcnt[15:0]});
         bcnt = 0;
         lcnt = 0;
      end else begin
         bcnt += (meas_busy === 1'b1);
         lcnt += (led_drive_on === 1'b1);
      end
   end

   initial begin
      seed = 32'h3a25;
      r = 32'h0;
      {hsel, hwrite, meas_start, hresetn} = 4'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 4; i++) begin
         rd(idxs[i], i == 3 ? 8'h65 : i == 1 ? 8'h04 : 8'h00);
      end
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         bus(idxs[i], 1'b1, 32'hffffffff);
         rd(idxs[i], msks[i]);
      end
      bus(8'h0d, 1'b1, 32'hffffffff);
      rd(8'h0d, 8'h00);
      $display("test register access done");
      // Recovery pairing with the gain lies outside this block.
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         // Gains six and seven break the host's limit on purpose, to show nothing clamps them.
         meas(i[2:0], (r[7:0] & 8'hfb) | {5'h0, i[0], 2'h0},
              i % 3 == 0 ? 8'h03 : i % 3 == 1 ? 8'h00 : r[15:8],
              i % 3 == 0 ? 8'h75 : i % 3 == 1 ? 8'h65 : r[23:16]);
      end
      $display("test measurements done");
      repeat (2) @(posedge hclk);
      finish_test();
   end
endmodule // testbench
